// File: hdl/dmx_pkg.sv
// Constants shared by the six-channel transfer control block.
// Assumes a 12-bit AXI4-Lite byte address space with 32-bit data words.
package dmx_pkg;
    localparam int NCH = 6;
    // Global register byte offsets
    localparam logic [11:0] OFF_PREC = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_MASK = 12'h008;
    localparam logic [11:0] OFF_EIDX0 = 12'h010;
    localparam logic [11:0] OFF_EIDX1 = 12'h014;
    localparam logic [11:0] OFF_FIDX0 = 12'h018;
    localparam logic [11:0] OFF_FIDX1 = 12'h01c;
    // Channel page: address[11:8] page, [7:5] channel, [4:2] register
    localparam logic [3:0] CH_PAGE = 4'h1;
    localparam int PAGE_MSB = 11;
    localparam int PAGE_LSB = 8;
    localparam int CH_MSB = 7;
    localparam int CH_LSB = 5;
    localparam int REG_MSB = 4;
    localparam int REG_LSB = 2;
    localparam logic [2:0] REG_SRC = 3'h0;
    localparam logic [2:0] REG_DST = 3'h1;
    localparam logic [2:0] REG_CNT = 3'h2;
    localparam logic [2:0] REG_SYN = 3'h3;
    localparam logic [2:0] REG_MODE = 3'h4;
    // Mode control bits
    localparam int MODE_W = 6;
    localparam int MODE_EN = 0;
    localparam int MODE_SSEL = 1;
    localparam int MODE_DSEL = 2;
    localparam int MODE_IE = 3;
    localparam int MODE_INTERRUPT_MODE_BIT = 4;
    localparam int MODE_ABU = 5;
    // Sync and frame count fields
    localparam int SYNC_LSB = 12;
    localparam int SYNC_W = 4;
    localparam int FRAME_W = 8;
    localparam logic [3:0] SYN_NONE = 4'h0;
    localparam logic [3:0] SYN_P0RX = 4'h1;
    localparam logic [3:0] SYN_P0TX = 4'h2;
    localparam logic [3:0] SYN_P1RX = 4'h5;
    localparam logic [3:0] SYN_P1TX = 4'h6;
    localparam logic [3:0] SYN_T0 = 4'hd;
    localparam logic [3:0] SYN_EXT3 = 4'he;
    localparam logic [3:0] SYN_T1 = 4'hf;
    // Interrupt route select field
    localparam int ROUTE_LSB = 0;
    localparam int ROUTE_W = 2;
    localparam logic [1:0] ROUTE_NONDMA = 2'h0;
    localparam logic [1:0] ROUTE_CH23 = 2'h1;
    localparam logic [1:0] ROUTE_ALL = 2'h2;
    localparam logic [1:0] ROUTE_RSVD = 2'h3;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hdl/dmx_top.sv
// Six-channel transfer control: index adjust, sync pacing, interrupts and line routing.
// Assumes peripheral events and interrupt sources run on CORE_CLK_IN.
// Behaviour
// - Mid-frame element adds selected element index
// - Last element of frame adds frame index
// - No interrupt unless interrupt enable set
// - Autobuffer: full only, or half and full
// - Multi-frame mode 0: interrupt at block end
// - Multi-frame mode 1: each frame and block
// - Sync code zero runs unsynchronised
// - Codes 1,2,5,6 pick serial port events
// - Codes d,e,f pick timers, external three
// - Separate interrupt output per channel
// - Channels 1,2,3 share lines 7,10,11
// - Channel 0 shares line 6
// - Reset deselects channel interrupts on lines
// - Route field selects line sources
// - Element counter decrements each mid-frame element, reloads on the last
// - Frame counter decrements on frame end, except in autobuffer mode
// - Two element and two frame index registers
module dmx_top import dmx_pkg::*; (
    input wire logic CORE_CLK_IN, // Core clock
    input wire logic RST_N_IN, // Synchronous reset, active low
    input wire logic [11:0] S_AXI_AWADDR_IN, // Write address
    input wire logic S_AXI_AWVALID_IN, // Write address valid
    output logic S_AXI_AWREADY_OUT, // Write address ready
    input wire logic [31:0] S_AXI_WDATA_IN, // Write data
    input wire logic [3:0] S_AXI_WSTRB_IN, // Write byte strobes
    input wire logic S_AXI_WVALID_IN, // Write data valid
    output logic S_AXI_WREADY_OUT, // Write data ready
    output logic [1:0] S_AXI_BRESP_OUT, // Write response
    output logic S_AXI_BVALID_OUT, // Write response valid
    input wire logic S_AXI_BREADY_IN, // Write response ready
    input wire logic [11:0] S_AXI_ARADDR_IN, // Read address
    input wire logic S_AXI_ARVALID_IN, // Read address valid
    output logic S_AXI_ARREADY_OUT, // Read address ready
    output logic [31:0] S_AXI_RDATA_OUT, // Read data
    output logic [1:0] S_AXI_RRESP_OUT, // Read response
    output logic S_AXI_RVALID_OUT, // Read valid
    input wire logic S_AXI_RREADY_IN, // Read ready
    input wire logic PORT0_RX_EVT_IN, // Serial port 0 receive event
    input wire logic PORT0_TX_EVT_IN, // Serial port 0 transmit event
    input wire logic PORT1_RX_EVT_IN, // Serial port 1 receive event
    input wire logic PORT1_TX_EVT_IN, // Serial port 1 transmit event
    input wire logic TIMER0_EVT_IN, // Timer 0 interrupt event
    input wire logic EXT3_EVT_IN, // External interrupt 3 event
    input wire logic TIMER1_IRQ_IN, // Timer 1 interrupt, sync and line 7
    input wire logic PORT1_RX_IRQ_IN, // Port 1 receive interrupt for line 10
    input wire logic PORT1_TX_IRQ_IN, // Port 1 transmit interrupt for line 11
    input wire logic LINE6_OTHER_IN, // Non-channel source of line 6
    output logic [NCH-1:0] CHAN_IRQ_OUT, // Per-channel interrupt pulses
    output logic LINE6_OUT, // Shared CPU line 6
    output logic LINE7_OUT, // Shared CPU line 7
    output logic LINE10_OUT, // Shared CPU line 10
    output logic LINE11_OUT, // Shared CPU line 11
    output logic IRQ_OUT // Masked sticky status summary
);
    logic aw_full, w_full, do_wr, rvalid, bvalid;
    logic [11:0] aw_addr;
    logic [31:0] w_data, wval, wclr, rdata;
    logic [3:0] w_strb;
    logic [1:0] bresp, rresp, route;
    logic [15:0] eidx0, eidx1, fidx0, fidx1;
    logic [15:0] src [NCH];
    logic [15:0] dst [NCH];
    logic [15:0] ecnt [NCH];
    logic [15:0] erel [NCH];
    logic [FRAME_W-1:0] frm [NCH];
    logic [SYNC_W-1:0] syn [NCH];
    logic [MODE_W-1:0] mode [NCH];
    logic [NCH-1:0] pend, step, last, half, ie_v, interrupt_mode_bit_v, abu_v, frm_nz, irq_ev, ch_wr;
    logic [NCH-1:0] chan_pulse, stat, mask;
    logic [3:0] lines;
    logic irq;

    // Byte-lane merge of a write into an existing word
    function automatic logic [31:0] wm(input logic [31:0] o, input logic [31:0] d,
                                       input logic [3:0] s);
        wm = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                wm[b*8 +: 8] = d[b*8 +: 8];
            end
        end
    endfunction

    // True when the address names a channel register
    function automatic logic in_ch(input logic [11:0] a);
        in_ch = (a[PAGE_MSB:PAGE_LSB] == CH_PAGE) && (int'(a[CH_MSB:CH_LSB]) < NCH)
                && (a[REG_MSB:REG_LSB] <= REG_MODE) && (a[REG_LSB-1:0] == 2'h0);
    endfunction

    // Decode for both bus directions; unmapped words answer with an error
    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = in_ch(a) || a == OFF_PREC || a == OFF_STAT || a == OFF_MASK
                  || a == OFF_EIDX0 || a == OFF_EIDX1 || a == OFF_FIDX0 || a == OFF_FIDX1;
    endfunction

    // Register read value, also the base for byte-merged writes
    function automatic logic [31:0] rd_word(input logic [11:0] a);
        logic [2:0] c;
        c = a[CH_MSB:CH_LSB];
        rd_word = '0;
        if (in_ch(a)) begin
            case (a[REG_MSB:REG_LSB])
                REG_SRC: rd_word[15:0] = src[c];
                REG_DST: rd_word[15:0] = dst[c];
                REG_CNT: rd_word[15:0] = ecnt[c];
                REG_SYN: rd_word = {16'h0, syn[c], 4'h0, frm[c]};
                default: rd_word[MODE_W-1:0] = mode[c];
            endcase
        end else begin
            case (a)
                OFF_PREC: rd_word[ROUTE_LSB +: ROUTE_W] = route;
                OFF_STAT: rd_word[NCH-1:0] = stat;
                OFF_MASK: rd_word[NCH-1:0] = mask;
                OFF_EIDX0: rd_word[15:0] = eidx0;
                OFF_EIDX1: rd_word[15:0] = eidx1;
                OFF_FIDX0: rd_word[15:0] = fidx0;
                OFF_FIDX1: rd_word[15:0] = fidx1;
                default: rd_word = '0;
            endcase
        end
    endfunction

    // Selected sync event; reserved codes never fire
    function automatic logic sync_hit(input logic [3:0] s);
        case (s)
            SYN_P0RX: sync_hit = PORT0_RX_EVT_IN;
            SYN_P0TX: sync_hit = PORT0_TX_EVT_IN;
            SYN_P1RX: sync_hit = PORT1_RX_EVT_IN;
            SYN_P1TX: sync_hit = PORT1_TX_EVT_IN;
            SYN_T0: sync_hit = TIMER0_EVT_IN;
            SYN_EXT3: sync_hit = EXT3_EVT_IN;
            SYN_T1: sync_hit = TIMER1_IRQ_IN;
            default: sync_hit = 1'b0;
        endcase
    endfunction

    // Post-adjust by element index, or by frame index on a frame's last element
    function automatic logic [15:0] adj(input logic [15:0] a, input logic l,
                                        input logic s);
        logic [15:0] e, f;
        e = s ? eidx1 : eidx0;
        f = s ? fidx1 : fidx0;
        adj = a + (l ? f : e);
    endfunction

    // Bus handshakes; one write and one read in flight at a time
    assign S_AXI_AWREADY_OUT = !aw_full;
    assign S_AXI_WREADY_OUT = !w_full;
    assign S_AXI_ARREADY_OUT = !rvalid;
    assign S_AXI_BVALID_OUT = bvalid;
    assign S_AXI_BRESP_OUT = bresp;
    assign S_AXI_RVALID_OUT = rvalid;
    assign S_AXI_RRESP_OUT = rresp;
    assign S_AXI_RDATA_OUT = rdata;
    assign do_wr = aw_full && w_full && !bvalid;
    assign wclr = wm(32'h0, w_data, w_strb);
    assign CHAN_IRQ_OUT = chan_pulse;
    assign {LINE11_OUT, LINE10_OUT, LINE7_OUT, LINE6_OUT} = lines;
    assign IRQ_OUT = irq;

    // Merge base re-read every cycle, since the engine may move the register meanwhile
    always_comb begin
        wval = wm(rd_word(aw_addr), w_data, w_strb);
    end

    // Write channel: address and data may arrive in either order
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (S_AXI_AWVALID_IN && !aw_full) begin
                aw_full <= 1'b1;
                aw_addr <= S_AXI_AWADDR_IN;
            end
            if (S_AXI_WVALID_IN && !w_full) begin
                w_full <= 1'b1;
                w_data <= S_AXI_WDATA_IN;
                w_strb <= S_AXI_WSTRB_IN;
            end
            if (do_wr) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                bvalid <= 1'b1;
                bresp <= addr_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY_IN) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read channel: data one cycle after the address is taken
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (S_AXI_ARVALID_IN && !rvalid) begin
            rvalid <= 1'b1;
            rdata <= rd_word(S_AXI_ARADDR_IN);
            rresp <= addr_ok(S_AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY_IN) begin
            rvalid <= 1'b0;
        end
    end

    // Global control: route select, mask, index registers
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            route <= ROUTE_NONDMA;
            mask <= '0;
            eidx0 <= '0;
            eidx1 <= '0;
            fidx0 <= '0;
            fidx1 <= '0;
        end else if (do_wr) begin
            case (aw_addr)
                OFF_PREC: route <= wval[ROUTE_LSB +: ROUTE_W];
                OFF_MASK: mask <= wval[NCH-1:0];
                OFF_EIDX0: eidx0 <= wval[15:0];
                OFF_EIDX1: eidx1 <= wval[15:0];
                OFF_FIDX0: fidx0 <= wval[15:0];
                OFF_FIDX1: fidx1 <= wval[15:0];
                default: ;
            endcase
        end
    end

    // Per-channel step and interrupt decisions
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            ch_wr[c] = do_wr && in_ch(aw_addr) && aw_addr[CH_MSB:CH_LSB] == 3'(c);
            ie_v[c] = mode[c][MODE_IE];
            interrupt_mode_bit_v[c] = mode[c][MODE_INTERRUPT_MODE_BIT];
            abu_v[c] = mode[c][MODE_ABU];
            frm_nz[c] = frm[c] != '0;
            last[c] = ecnt[c] == '0;
            step[c] = mode[c][MODE_EN] && (syn[c] == SYN_NONE || pend[c]);
            half[c] = !last[c] && ecnt[c] == {1'b0, erel[c][15:1]};
            if (abu_v[c]) begin
                irq_ev[c] = step[c] && (last[c] || (interrupt_mode_bit_v[c] && half[c]));
            end else begin
                irq_ev[c] = step[c] && last[c] && (!frm_nz[c] || interrupt_mode_bit_v[c]);
            end
            irq_ev[c] = irq_ev[c] && ie_v[c];
        end
    end

    // Pending sync events; an event in the consuming cycle stays pending
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            pend <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                pend[c] <= (pend[c] && !step[c]) || sync_hit(syn[c]);
            end
        end
    end

    // Channel state; a software write in the same cycle overrides the engine
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            for (int c = 0; c < NCH; c++) begin
                src[c] <= '0;
                dst[c] <= '0;
                ecnt[c] <= '0;
                erel[c] <= '0;
                frm[c] <= '0;
                syn[c] <= SYN_NONE;
                mode[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (step[c]) begin
                    src[c] <= adj(src[c], last[c], mode[c][MODE_SSEL]);
                    dst[c] <= adj(dst[c], last[c], mode[c][MODE_DSEL]);
                    if (!last[c]) begin
                        ecnt[c] <= ecnt[c] - 16'h1;
                    end else begin
                        ecnt[c] <= erel[c];
                        if (!abu_v[c]) begin
                            if (frm_nz[c]) begin
                                frm[c] <= frm[c] - 8'h1;
                            end else begin
                                mode[c][MODE_EN] <= 1'b0;
                            end
                        end
                    end
                end
                if (ch_wr[c]) begin
                    case (aw_addr[REG_MSB:REG_LSB])
                        REG_SRC: src[c] <= wval[15:0];
                        REG_DST: dst[c] <= wval[15:0];
                        REG_CNT: begin
                            ecnt[c] <= wval[15:0];
                            erel[c] <= wval[15:0];
                        end
                        REG_SYN: begin
                            syn[c] <= wval[SYNC_LSB +: SYNC_W];
                            frm[c] <= wval[FRAME_W-1:0];
                        end
                        default: mode[c] <= wval[MODE_W-1:0];
                    endcase
                end
            end
        end
    end

    // Pulses, sticky status (set beats clear) and summary level
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            chan_pulse <= '0;
            stat <= '0;
            irq <= 1'b0;
        end else begin
            chan_pulse <= irq_ev;
            if (do_wr && aw_addr == OFF_STAT) begin
                stat <= (stat & ~wclr[NCH-1:0]) | irq_ev;
            end else begin
                stat <= stat | irq_ev;
            end
            irq <= |(stat & mask);
        end
    end

    // Shared line routing, aligned with the channel pulses
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            lines <= '0;
        end else begin
            unique case (route)
                ROUTE_NONDMA: lines <= {PORT1_TX_IRQ_IN, PORT1_RX_IRQ_IN, TIMER1_IRQ_IN,
                                        LINE6_OTHER_IN};
                ROUTE_CH23: lines <= {irq_ev[3], irq_ev[2], TIMER1_IRQ_IN,
                                      LINE6_OTHER_IN};
                ROUTE_ALL: lines <= irq_ev[3:0];
                ROUTE_RSVD: lines <= {PORT1_TX_IRQ_IN, PORT1_RX_IRQ_IN, TIMER1_IRQ_IN,
                                      LINE6_OTHER_IN};
            endcase
        end
    end

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence s_mid0;
        step[0] && !last[0] && !ch_wr[0];
    endsequence
    sequence s_last0;
        step[0] && last[0] && !ch_wr[0];
    endsequence
    sequence s_abu_full;
        (step & last & abu_v & ie_v) != '0;
    endsequence
    property p_ie_gate;
        1'b1 |=> (chan_pulse & $past(step & ~ie_v)) == '0;
    endproperty
    a_ie_gate: assert property (p_ie_gate) else $error("pulse with interrupts off");
    property p_abu_half;
        1'b1 |=> (chan_pulse & $past(step & ~last & abu_v & ~interrupt_mode_bit_v)) == '0;
    endproperty
    a_abu_half: assert property (p_abu_half) else $error("half pulse in mode 0");
    property p_abu_full;
        s_abu_full |=> (chan_pulse & $past(step & last & abu_v & ie_v)) != '0;
    endproperty
    a_abu_full: assert property (p_abu_full) else $error("no full buffer pulse");
    property p_mf_frame0;
        1'b1 |=> (chan_pulse & $past(step & last & ~abu_v & ~interrupt_mode_bit_v & frm_nz)) == '0;
    endproperty
    a_mf_frame0: assert property (p_mf_frame0) else $error("frame pulse in mode 0");
    property p_mf_frame1;
        s_last0 ##0 (ie_v[0] && interrupt_mode_bit_v[0] && !abu_v[0]) |=> chan_pulse[0] ##1 !chan_pulse[0]
            || $past(step[0] && last[0]);
    endproperty
    a_mf_frame1: assert property (p_mf_frame1) else $error("missing frame pulse");
    property p_elem_idx;
        s_mid0 |=> src[0] == $past(src[0]) + $past(mode[0][MODE_SSEL] ? eidx1 : eidx0);
    endproperty
    a_elem_idx: assert property (p_elem_idx) else $error("element index wrong");
    property p_frame_idx;
        s_last0 |=> dst[0] == $past(dst[0]) + $past(mode[0][MODE_DSEL] ? fidx1 : fidx0);
    endproperty
    a_frame_idx: assert property (p_frame_idx) else $error("frame index wrong");
    property p_ecnt;
        s_mid0 |=> ecnt[0] == $past(ecnt[0]) - 16'h1;
    endproperty
    a_ecnt: assert property (p_ecnt) else $error("element count not decremented");
    property p_frm;
        s_last0 ##0 (!abu_v[0] && frm_nz[0]) |=> frm[0] == $past(frm[0]) - 8'h1;
    endproperty
    a_frm: assert property (p_frm) else $error("frame count not decremented");
    property p_nosync;
        mode[0][MODE_EN] && syn[0] == SYN_NONE |-> step[0];
    endproperty
    a_nosync: assert property (p_nosync) else $error("unsynced channel stalled");
    property p_sync_p1rx;
        syn[3] == SYN_P1RX && PORT1_RX_EVT_IN && mode[3][MODE_EN] && !step[3] && !ch_wr[3]
            |=> step[3];
    endproperty
    a_sync_p1rx: assert property (p_sync_p1rx) else $error("port event not used");
    property p_sync_t0;
        syn[5] == SYN_T0 && TIMER0_EVT_IN && mode[5][MODE_EN] && !step[5] && !ch_wr[5]
            |=> step[5];
    endproperty
    a_sync_t0: assert property (p_sync_t0) else $error("timer event not used");
    property p_route_ch23;
        route == ROUTE_CH23 |=> LINE10_OUT == $past(irq_ev[2])
            && LINE7_OUT == $past(TIMER1_IRQ_IN);
    endproperty
    a_route_ch23: assert property (p_route_ch23) else $error("route 1 wrong");
    property p_route_all;
        route == ROUTE_ALL |=> LINE6_OUT == $past(irq_ev[0]) && LINE7_OUT == $past(irq_ev[1]);
    endproperty
    a_route_all: assert property (p_route_all) else $error("route 2 wrong");
    property p_route_rsvd;
        route == ROUTE_RSVD |=> LINE11_OUT == $past(PORT1_TX_IRQ_IN)
            && LINE6_OUT == $past(LINE6_OTHER_IN);
    endproperty
    a_route_rsvd: assert property (p_route_rsvd) else $error("channel on reserved route");
endmodule

// File: verif/dmx_peer.sv
// Far-side model: peripheral event pulses and non-channel interrupt sources.
// Assumes it shares the core clock and drives just after the rising edge.
module dmx_peer (
    input wire logic clk_in, // Core clock
    output logic [9:0] sig_out // Events 0-5, timer 1, line 6 other, port 1 rx, tx
);
    timeunit 1ns;
    timeprecision 1ps;
    initial sig_out = 10'h000;
    // One-cycle pulse, then a gap so that each event makes one step only
    task fire(input int k);
        @(posedge clk_in);
        sig_out[k] <= 1'b1;
        @(posedge clk_in);
        sig_out[k] <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask
    // Levels of timer 1, line 6 other and port 1 interrupts
    task set_lvl(input logic [3:0] v);
        @(posedge clk_in);
        sig_out[9:6] <= v;
    endtask
endmodule

// File: verif/dmx_top_test.sv
// Bench for the transfer control block: bus tasks, routing, index and interrupt checks.
// Assumes the peer model supplies every event and non-channel interrupt input.
module dmx_top_test import dmx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, irq_out;
    logic [1:0] bresp, rresp;
    logic [5:0] chirq;
    logic [3:0] lines;
    logic [9:0] sig;
    int n_mismatch = 0, n_compared = 0, cyc = 0, lc = 0, lc0, b;
    int pc [6] = '{0, 0, 0, 0, 0, 0};
    // Channel, sync code, count, frame, mode, event, events, pulses
    int tab [8][8] = '{'{1, 4'h1, 0, 0, 8'h09, 0, 1, 1}, '{1, 4'h2, 0, 0, 8'h09, 1, 1, 1},
        '{1, 4'hf, 0, 0, 8'h09, 6, 1, 1}, '{2, 4'h6, 1, 1, 8'h19, 3, 4, 2},
        '{3, 4'h5, 1, 1, 8'h09, 2, 4, 1}, '{4, 4'he, 0, 0, 8'h11, 5, 1, 0},
        '{4, 4'h3, 0, 0, 8'h09, 0, 1, 0}, '{5, 4'hd, 3, 0, 8'h39, 4, 4, 2}};
    dmx_peer peer (.clk_in(clk), .sig_out(sig));
    dmx_top DUT (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr),
        .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .PORT0_RX_EVT_IN(sig[0]), .PORT0_TX_EVT_IN(sig[1]),
        .PORT1_RX_EVT_IN(sig[2]), .PORT1_TX_EVT_IN(sig[3]), .TIMER0_EVT_IN(sig[4]),
        .EXT3_EVT_IN(sig[5]), .TIMER1_IRQ_IN(sig[6]), .LINE6_OTHER_IN(sig[7]),
        .PORT1_RX_IRQ_IN(sig[8]), .PORT1_TX_IRQ_IN(sig[9]), .CHAN_IRQ_OUT(chirq),
        .LINE6_OUT(lines[3]), .LINE7_OUT(lines[2]), .LINE10_OUT(lines[1]),
        .LINE11_OUT(lines[0]), .IRQ_OUT(irq_out));
    initial forever #10 clk = ~clk;
    task stop_test;
        $display("Counts: compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    // Pulse counters and a cycle ceiling that cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        lc <= lc + $countones(lines);
        for (int c = 0; c < NCH; c++)
            if (chirq[c] === 1'b1)
                pc[c] <= pc[c] + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    function automatic logic [11:0] ca(input int c, input logic [2:0] r);
        return {CH_PAGE, 3'(c), r, 2'b00};
    endfunction
    // Write with both channels offered together; each released once taken
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask
    task rchk(input string nm, input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(nm, e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        peer.set_lvl(4'b1011);
        repeat (3) @(posedge clk);
        chk("lines route 00", 32'h0000000d, 32'(lines));
        wr(OFF_PREC, 32'h1, RESP_OKAY);
        peer.set_lvl(4'b1111);
        repeat (3) @(posedge clk);
        chk("lines route 01", 32'h0000000c, 32'(lines));
        wr(OFF_PREC, 32'h3, RESP_OKAY);
        peer.set_lvl(4'b0110);
        repeat (3) @(posedge clk);
        chk("lines route 11", 32'h0000000a, 32'(lines));
        peer.set_lvl(4'b0000);
        wr(OFF_PREC, 32'h2, RESP_OKAY);
        rchk("route", OFF_PREC, 32'h2, RESP_OKAY);
        wr(12'h0fc, 32'h1, RESP_SLVERR);
        rchk("unmapped", 12'h0fc, 32'h0, RESP_SLVERR);
        $display("Test routing and bus done");
        // Two frames of three elements: two element steps, then a frame step
        wr(OFF_EIDX0, 32'h2, RESP_OKAY);
        wr(OFF_EIDX1, 32'h3, RESP_OKAY);
        wr(OFF_FIDX0, 32'h100, RESP_OKAY);
        wr(OFF_FIDX1, 32'h200, RESP_OKAY);
        wr(ca(0, REG_SRC), 32'h1000, RESP_OKAY);
        wr(ca(0, REG_DST), 32'h2000, RESP_OKAY);
        wr(ca(0, REG_SYN), 32'h1, RESP_OKAY);
        wr(ca(0, REG_CNT), 32'h2, RESP_OKAY);
        lc0 = lc;
        wr(ca(0, REG_MODE), 32'h1d, RESP_OKAY);
        repeat (8) @(posedge clk);
        rchk("src", ca(0, REG_SRC), 32'h1208, RESP_OKAY);
        rchk("dst", ca(0, REG_DST), 32'h240c, RESP_OKAY);
        rchk("count", ca(0, REG_CNT), 32'h2, RESP_OKAY);
        rchk("mode", ca(0, REG_MODE), 32'h1c, RESP_OKAY);
        rchk("status", OFF_STAT, 32'h1, RESP_OKAY);
        chk("ch0 pulses", 32'h2, pc[0]);
        chk("irq masked", 32'h0, 32'(irq_out));
        wr(OFF_MASK, 32'h1, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("irq unmasked", 32'h1, 32'(irq_out));
        wr(OFF_STAT, 32'h1, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, 32'(irq_out));
        rchk("status cleared", OFF_STAT, 32'h0, RESP_OKAY);
        $display("Test index and interrupt done");
        // Each row waits for its sync event; a reserved code never steps
        for (int i = 0; i < 8; i++) begin
            b = pc[tab[i][0]];
            wr(ca(tab[i][0], REG_SYN), {16'h0, 4'(tab[i][1]), 4'h0, 8'(tab[i][3])}, RESP_OKAY);
            wr(ca(tab[i][0], REG_CNT), 32'(tab[i][2]), RESP_OKAY);
            wr(ca(tab[i][0], REG_MODE), 32'(tab[i][4]), RESP_OKAY);
            repeat (4) @(posedge clk);
            chk("pulses before event", b, pc[tab[i][0]]);
            repeat (tab[i][6]) peer.fire(tab[i][5]);
            repeat (4) @(posedge clk);
            chk("pulses after events", b + tab[i][7], pc[tab[i][0]]);
        end
        chk("line pulses", 32'h8, lc - lc0);
        rchk("status", OFF_STAT, 32'h2e, RESP_OKAY);
        $display("Test sync and interrupt modes done");
        stop_test();
    end
endmodule
